// ==== hw/dtcp_pkg.sv ====
// dtcp_pkg: register map, field positions and types of the timer pair
// assumes a 32-bit Avalon-MM slave with byte addresses
`default_nettype none
package dtcp_pkg;
	localparam int ADDR_W = 6;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_MODE = 6'h04;
	localparam logic [5:0] OFS_LO0 = 6'h08;
	localparam logic [5:0] OFS_LO1 = 6'h0C;
	localparam logic [5:0] OFS_HI0 = 6'h10;
	localparam logic [5:0] OFS_HI1 = 6'h14;
	localparam logic [5:0] OFS_CKC = 6'h18;
	localparam logic [5:0] OFS_IEN = 6'h1C;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_F1 = 7;
	localparam int CTRL_R1 = 6;
	localparam int CTRL_F0 = 5;
	localparam int CTRL_R0 = 4;
	localparam int CKC_T0SEL = 0;
	localparam int CKC_T1SEL = 1;
	localparam int CKC_X2 = 2;
	localparam int IEN_GLB = 7;
	localparam int IEN_ET1 = 3;
	localparam int IEN_ET0 = 1;
	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_CFG = 4'h0;
	localparam int PER_PERIODS = 6;
	localparam logic [2:0] PER_LAST = 3'(PER_PERIODS - 1);
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_13 = 2'h0,
		MODE_16 = 2'h1,
		MODE_RELOAD = 2'h2,
		MODE_SPLIT = 2'h3
	} dtcp_mode_t;
	typedef struct packed {
		logic gate;
		logic src;
		dtcp_mode_t mode;
	} dtcp_cfg_t;
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
		logic ovf;
	} dtcp_cnt_t;
endpackage
`default_nettype wire

// ==== hw/dtcp_tick.sv ====
// dtcp_tick: timer clock select and peripheral-cycle strobe
// assumes clock is the oscillator clock
`default_nettype none
module dtcp_tick
	import dtcp_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// control
	input wire logic fixed_half,
	input wire logic double_speed,
	// strobe
	output logic tick
);
	logic half_reg, half_next;
	logic [2:0] cnt_reg, cnt_next;
	logic en;
	// ----------------------------------------
	// timer clock: osc/2 or osc
	// ----------------------------------------
	always_comb begin
		en = (fixed_half | ~double_speed) ? half_reg : 1'b1;
		half_next = ~half_reg;
		cnt_next = cnt_reg;
		if (en) begin
			cnt_next = (cnt_reg == PER_LAST) ? 3'h0 : 3'(cnt_reg + 3'h1);
		end
		tick = en & (cnt_reg == PER_LAST);
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			half_reg <= 1'b0;
			cnt_reg <= 3'h0;
		end else begin
			half_reg <= half_next;
			cnt_reg <= cnt_next;
		end
	end
endmodule
`default_nettype wire

// ==== hw/dtcp_top.sv ====
// dtcp_top: two 16-bit timer/counters behind an Avalon-MM slave
// assumes pins are asynchronous; irq acks come from the cpu clock domain
`default_nettype none
module dtcp_top
	import dtcp_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// pins
	input wire logic event_pin0,
	input wire logic event_pin1,
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	// interrupt requests and vector acks
	input wire logic irq_ack0,
	input wire logic irq_ack1,
	output logic timer0_irq,
	output logic timer1_irq,
	// serial baud source
	output logic timer1_overflow_pulse
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [3:0] s1_reg, s2_reg;
	logic [1:0] prev_reg, prev_next;
	logic [7:0] lo_reg [2];
	logic [7:0] hi_reg [2];
	logic [7:0] lo_next [2];
	logic [7:0] hi_next [2];
	dtcp_cfg_t cfg_reg [2];
	dtcp_cfg_t cfg_next [2];
	logic [1:0] run_reg, run_next, flag_reg, flag_next;
	logic [2:0] ckc_reg, ckc_next;
	logic [2:0] ien_reg, ien_next;
	logic done_reg, done_next, baud_reg, baud_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] tick, edge_ev, en, inc;
	logic split, hi0_inc, hi0_ovf, wr, ovf_set0, ovf_set1;
	logic [7:0] hi0_split;
	logic [1:0] pin_s, irq_s;
	dtcp_cnt_t c0, c1;

	function automatic dtcp_cnt_t step(dtcp_mode_t m, logic [7:0] hi, logic [7:0] lo,
			logic inc_en, logic halt);
		dtcp_cnt_t r;
		logic c;
		r = {hi, lo, 1'b0};
		c = 1'b0;
		if (inc_en) begin
			case (m)
				MODE_13: begin
					{c, r.lo[4:0]} = 6'({1'b0, lo[4:0]} + 6'h01);
					if (c) begin
						{r.ovf, r.hi} = 9'({1'b0, hi} + 9'h001);
					end
				end
				MODE_16: {r.ovf, r.hi, r.lo} = 17'({1'b0, hi, lo} + 17'h00001);
				MODE_RELOAD: begin
					r.ovf = (lo == 8'hFF);
					r.lo = r.ovf ? hi : 8'(lo + 8'h01);
				end
				MODE_SPLIT: begin
					if (!halt) begin
						{r.ovf, r.lo} = 9'({1'b0, lo} + 9'h001);
					end
				end
				default: r = {hi, lo, 1'b0};
			endcase
		end
		return r;
	endfunction

	// ----------------------------------------
	// pin synchronisers and strobes
	// ----------------------------------------
	assign pin_s = s2_reg[1:0];
	assign irq_s = s2_reg[3:2];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_tick
			dtcp_tick u_tick (
				.clock(clock),
				.sys_rst(sys_rst),
				.fixed_half(ckc_reg[gi]),
				.double_speed(ckc_reg[CKC_X2]),
				.tick(tick[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// counting
	// ----------------------------------------
	always_comb begin
		split = (cfg_reg[0].mode == MODE_SPLIT);
		for (int i = 0; i < 2; i++) begin
			edge_ev[i] = tick[i] & prev_reg[i] & ~pin_s[i];
			prev_next[i] = tick[i] ? pin_s[i] : prev_reg[i];
		end
		en[0] = run_reg[0] & (~cfg_reg[0].gate | irq_s[0]);
		en[1] = (run_reg[1] | split) & (~cfg_reg[1].gate | irq_s[1]);
		for (int i = 0; i < 2; i++) begin
			inc[i] = en[i] & (cfg_reg[i].src ? edge_ev[i] : tick[i]);
		end
		c0 = step(cfg_reg[0].mode, hi_reg[0], lo_reg[0], inc[0], 1'b0);
		c1 = step(cfg_reg[1].mode, hi_reg[1], lo_reg[1], inc[1], 1'b1);
		hi0_inc = split & run_reg[1] & tick[1];
		{hi0_ovf, hi0_split} = 9'({1'b0, hi_reg[0]} + {8'h00, hi0_inc});
		ovf_set0 = c0.ovf;
		ovf_set1 = (c1.ovf & ~split) | hi0_ovf;
		baud_next = c1.ovf;
	end

	// ----------------------------------------
	// register file and bus slave
	// ----------------------------------------
	always_comb begin
		wr = avs_write & done_reg & avs_byteenable[0];
		done_next = (avs_read | avs_write) & ~done_reg;
		avs_waitrequest = (avs_read | avs_write) & ~done_reg;
		lo_next[0] = c0.lo;
		hi_next[0] = split ? hi0_split : c0.hi;
		lo_next[1] = c1.lo;
		hi_next[1] = c1.hi;
		cfg_next = cfg_reg;
		run_next = run_reg;
		flag_next = flag_reg & ~{irq_ack1, irq_ack0};
		ckc_next = ckc_reg;
		ien_next = ien_reg;
		if (wr) begin
			case (avs_address)
				OFS_CTRL: begin
					run_next = {avs_writedata[CTRL_R1], avs_writedata[CTRL_R0]};
					flag_next = {avs_writedata[CTRL_F1], avs_writedata[CTRL_F0]};
				end
				OFS_MODE: {cfg_next[1], cfg_next[0]} = avs_writedata[7:0];
				OFS_LO0: lo_next[0] = avs_writedata[7:0];
				OFS_LO1: lo_next[1] = avs_writedata[7:0];
				OFS_HI0: hi_next[0] = avs_writedata[7:0];
				OFS_HI1: hi_next[1] = avs_writedata[7:0];
				OFS_CKC: ckc_next = avs_writedata[2:0];
				OFS_IEN: ien_next = {avs_writedata[IEN_GLB], avs_writedata[IEN_ET1],
					avs_writedata[IEN_ET0]};
				default: ;
			endcase
		end
		flag_next = flag_next | {ovf_set1, ovf_set0};
		rdata_next = rdata_reg;
		if (avs_read & ~done_reg) begin
			case (avs_address)
				OFS_CTRL: rdata_next = {24'h000000, flag_reg[1], run_reg[1], flag_reg[0],
					run_reg[0], 4'h0};
				OFS_MODE: rdata_next = {24'h000000, cfg_reg[1], cfg_reg[0]};
				OFS_LO0: rdata_next = {24'h000000, lo_reg[0]};
				OFS_LO1: rdata_next = {24'h000000, lo_reg[1]};
				OFS_HI0: rdata_next = {24'h000000, hi_reg[0]};
				OFS_HI1: rdata_next = {24'h000000, hi_reg[1]};
				OFS_CKC: rdata_next = {29'h00000000, ckc_reg};
				OFS_IEN: rdata_next = {24'h000000, ien_reg[2], 3'h0, ien_reg[1], 1'b0,
					ien_reg[0], 1'b0};
				default: rdata_next = 32'h00000000;
			endcase
		end
		avs_readdata = rdata_reg;
		timer0_irq = flag_reg[0] & ien_reg[0] & ien_reg[2];
		timer1_irq = flag_reg[1] & ien_reg[1] & ien_reg[2];
		timer1_overflow_pulse = baud_reg;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s1_reg <= 4'h0;
			s2_reg <= 4'h0;
			prev_reg <= 2'h0;
			for (int i = 0; i < 2; i++) begin
				lo_reg[i] <= RST_BYTE;
				hi_reg[i] <= RST_BYTE;
				cfg_reg[i] <= RST_CFG;
			end
			run_reg <= 2'h0;
			flag_reg <= 2'h0;
			ckc_reg <= 3'h0;
			ien_reg <= 3'h0;
			done_reg <= 1'b0;
			baud_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end else begin
			s1_reg <= {ext_irq1_pin, ext_irq0_pin, event_pin1, event_pin0};
			s2_reg <= s1_reg;
			prev_reg <= prev_next;
			lo_reg <= lo_next;
			hi_reg <= hi_next;
			cfg_reg <= cfg_next;
			run_reg <= run_next;
			flag_reg <= flag_next;
			ckc_reg <= ckc_next;
			ien_reg <= ien_next;
			done_reg <= done_next;
			baud_reg <= baud_next;
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_lo_wrap;
		inc[0] && !wr && cfg_reg[0].mode == MODE_16 && lo_reg[0] == 8'hFF;
	endsequence
	sequence s_carry_done;
		lo_reg[0] == 8'h00 && hi_reg[0] == 8'($past(hi_reg[0]) + 8'h01);
	endsequence
	sequence s_spill_pre;
		inc[0] && !wr && cfg_reg[0].mode == MODE_13 && lo_reg[0][4:0] == 5'h1F;
	endsequence
	sequence s_spill_done;
		lo_reg[0][4:0] == 5'h00 && lo_reg[0][7:5] == $past(lo_reg[0][7:5])
			&& hi_reg[0] == 8'($past(hi_reg[0]) + 8'h01);
	endsequence

	a_cascade_carry: assert property (s_lo_wrap |=> s_carry_done)
		else $error("low wrap did not carry into high byte");
	a_run_keeps: assert property (wr && avs_address == OFS_CTRL && !run_reg[0]
		&& !split |=> lo_reg[0] == $past(lo_reg[0]) && hi_reg[0] == $past(hi_reg[0]))
		else $error("starting timer changed count");
	a_tick_spacing: assert property (tick[0] |=> !tick[0] [*5])
		else $error("timer tick closer than six timer clocks");
	a_tick1_spacing: assert property (tick[1] |=> !tick[1] [*5])
		else $error("timer1 tick closer than six timer clocks");
	a_pin_edge: assert property (edge_ev[0] && en[0] && cfg_reg[0].src && !wr
		&& cfg_reg[0].mode == MODE_16 |=> lo_reg[0] != $past(lo_reg[0]))
		else $error("falling pin edge not counted");
	a_run_gate: assert property (!run_reg[0] && !wr
		|=> lo_reg[0] == $past(lo_reg[0]))
		else $error("timer0 low byte moved while stopped");
	a_gate_hold: assert property (cfg_reg[0].gate && !irq_s[0] && !wr
		|=> lo_reg[0] == $past(lo_reg[0]))
		else $error("gated timer counted with pin low");
	a_ovf_flag: assert property (ovf_set0 |=> flag_reg[0])
		else $error("overflow did not set flag");
	a_ovf_flag1: assert property (ovf_set1 |=> flag_reg[1])
		else $error("timer1 overflow did not set flag");
	a_spill_carry: assert property (s_spill_pre |=> s_spill_done)
		else $error("prescaler spill did not carry into high byte");
	a_reload_val: assert property (inc[0] && !wr && cfg_reg[0].mode == MODE_RELOAD
		&& lo_reg[0] == 8'hFF |=> lo_reg[0] == $past(hi_reg[0]) && flag_reg[0])
		else $error("auto reload wrong");
	a_reload_keep: assert property (inc[0] && !wr && cfg_reg[0].mode == MODE_RELOAD
		|=> hi_reg[0] == $past(hi_reg[0]))
		else $error("reload changed the high byte");
	a_split_high: assert property (split && run_reg[1] && tick[1] && !wr
		|=> hi_reg[0] == 8'($past(hi_reg[0]) + 8'h01))
		else $error("split high byte did not count");
	a_split_flag: assert property (hi0_ovf |=> flag_reg[1])
		else $error("split high byte overflow did not set flag1");
	a_t1_halt: assert property (cfg_reg[1].mode == MODE_SPLIT && !wr
		|=> lo_reg[1] == $past(lo_reg[1]) && hi_reg[1] == $past(hi_reg[1]))
		else $error("timer1 moved in halt mode");
	a_t1_cascade: assert property (inc[1] && !wr && cfg_reg[1].mode == MODE_16
		&& lo_reg[1] == 8'hFF |=> lo_reg[1] == 8'h00 && hi_reg[1] == 8'($past(hi_reg[1]) + 8'h01))
		else $error("timer1 low wrap did not carry");
	a_irq_req: assert property (timer0_irq == (flag_reg[0] && ien_reg[0]
		&& ien_reg[2]))
		else $error("timer0 request mismatch");
	a_ack_clear: assert property (irq_ack0 && !ovf_set0 && !wr
		|=> !flag_reg[0])
		else $error("vector ack did not clear timer0 flag");
	a_baud_pulse: assert property (c1.ovf |=> timer1_overflow_pulse)
		else $error("timer1 overflow gave no baud pulse");
	a_bus_answer: assert property (avs_waitrequest |=> !avs_waitrequest)
		else $error("slave did not answer in one wait cycle");
endmodule
`default_nettype wire

// ==== testbench/tb_dtcp_top.sv ====
// tb_dtcp_top: register-level tests of the timer pair over avalon-mm
// assumes dtcp_pkg and dtcp_top compiled first; clock is 100 MHz
`default_nettype none
module tb_dtcp_top
	import dtcp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic event_pin0 = 1'b1;
	logic event_pin1 = 1'b1;
	logic ext_irq0_pin = 1'b0;
	logic ext_irq1_pin = 1'b0;
	logic irq_ack0 = 1'b0;
	logic irq_ack1 = 1'b0;
	logic timer0_irq;
	logic timer1_irq;
	logic timer1_overflow_pulse;
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [31:0] q;
	dtcp_top DUT (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .event_pin0(event_pin0), .event_pin1(event_pin1),
		.ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin), .irq_ack0(irq_ack0),
		.irq_ack1(irq_ack1), .timer0_irq(timer0_irq), .timer1_irq(timer1_irq),
		.timer1_overflow_pulse(timer1_overflow_pulse));
	initial begin
		forever #5 clock = ~clock;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus cycle: hold until waitrequest seen low, then release
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] r);
		int n;
		n = 0;
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0 && n < 50) begin
			@(posedge clock);
			n++;
		end
		r = avs_readdata;
		if (n >= 50) n_mismatch++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [31:0] r;
		acc(1'b1, a, d, 4'hF, r);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] r);
		acc(1'b0, a, 8'h00, 4'hF, r);
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
		logic [31:0] r;
		rd(a, r);
		chk(r, {24'h000000, e});
	endtask
	// preset, run until the high byte moves, then stop and compare
	task automatic step(input logic [5:0] lo_a, hi_a, input logic [7:0] md, run, lo, hi,
		elo, ehi, ectl);
		logic [31:0] r;
		logic [31:0] c;
		int n;
		wr(OFS_CTRL, 8'h00);
		wr(OFS_MODE, md);
		wr(lo_a, lo);
		wr(hi_a, hi);
		wr(OFS_CTRL, run);
		n = 0;
		r = {24'h000000, hi};
		while (r[7:0] === hi && n < 200) begin
			rd(hi_a, r);
			n++;
		end
		rd(OFS_CTRL, c);
		wr(OFS_CTRL, 8'h00);
		chk(c, {24'h000000, ectl});
		rdchk(lo_a, elo);
		rdchk(hi_a, ehi);
	endtask
	// cycles between two overflow pulses of timer 1
	task automatic per(input int exp);
		int c;
		c = 0;
		while (timer1_overflow_pulse !== 1'b1 && c < 500) begin
			@(posedge clock);
			c++;
		end
		@(posedge clock);
		c = 1;
		while (timer1_overflow_pulse !== 1'b1 && c < 500) begin
			@(posedge clock);
			c++;
		end
		chk(32'(c), 32'(exp));
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#300000;
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		for (int i = 0; i < 8; i++) begin
			rdchk(6'(i * 4), 8'h00);
		end
		rdchk(6'h20, 8'h00);
		wr(OFS_LO0, 8'h5A);
		acc(1'b1, OFS_LO0, 8'h33, 4'h0, q);
		rdchk(OFS_LO0, 8'h5A);
		step(OFS_LO0, OFS_HI0, 8'h01, 8'h10, 8'hFF, 8'h12, 8'h00, 8'h13, 8'h10);
		step(OFS_LO0, OFS_HI0, 8'h01, 8'h10, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h30);
		step(OFS_LO0, OFS_HI0, 8'h00, 8'h10, 8'hFF, 8'h07, 8'hE0, 8'h08, 8'h10);
		step(OFS_LO1, OFS_HI1, 8'h10, 8'h40, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hC0);
		step(OFS_LO0, OFS_HI0, 8'h03, 8'h40, 8'h33, 8'hFF, 8'h33, 8'h00, 8'hC0);
		// counter operation on falling pin edges
		wr(OFS_MODE, 8'h05);
		wr(OFS_LO0, 8'h00);
		wr(OFS_HI0, 8'h00);
		wr(OFS_CTRL, 8'h10);
		repeat (5) begin
			event_pin0 <= 1'b0;
			repeat (30) @(posedge clock);
			event_pin0 <= 1'b1;
			repeat (30) @(posedge clock);
		end
		wr(OFS_CTRL, 8'h00);
		rdchk(OFS_LO0, 8'h05);
		// gated timer
		wr(OFS_MODE, 8'h09);
		wr(OFS_LO0, 8'h00);
		wr(OFS_CTRL, 8'h10);
		repeat (60) @(posedge clock);
		rdchk(OFS_LO0, 8'h00);
		ext_irq0_pin <= 1'b1;
		repeat (120) @(posedge clock);
		wr(OFS_CTRL, 8'h00);
		rd(OFS_LO0, q);
		chk(32'(q >= 9 && q <= 11), 32'h00000001);
		// auto-reload, interrupt, acknowledge and mask
		wr(OFS_IEN, 8'h82);
		wr(OFS_MODE, 8'h02);
		wr(OFS_HI0, 8'hFE);
		wr(OFS_LO0, 8'hFE);
		wr(OFS_CTRL, 8'h10);
		for (int n = 0; n < 100 && timer0_irq !== 1'b1; n++) @(posedge clock);
		chk({31'h0, timer0_irq}, 32'h00000001);
		irq_ack0 <= 1'b1;
		@(posedge clock);
		irq_ack0 <= 1'b0;
		@(posedge clock);
		chk({31'h0, timer0_irq}, 32'h00000000);
		wr(OFS_IEN, 8'h02);
		repeat (40) @(posedge clock);
		chk({31'h0, timer0_irq}, 32'h00000000);
		rd(OFS_CTRL, q);
		chk({31'h0, q[CTRL_F0]}, 32'h00000001);
		wr(OFS_CTRL, 8'h00);
		rdchk(OFS_HI0, 8'hFE);
		// timer 1 reload period as baud source, per clock setting
		wr(OFS_MODE, 8'h20);
		wr(OFS_HI1, 8'hFD);
		wr(OFS_LO1, 8'hFD);
		wr(OFS_CTRL, 8'h40);
		per(36);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_CKC, 8'h04);
		wr(OFS_CTRL, 8'h40);
		per(18);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_CKC, 8'h06);
		wr(OFS_CTRL, 8'h40);
		per(36);
		wr(OFS_IEN, 8'h88);
		chk({31'h0, timer1_irq}, 32'h00000001);
		// timer 1 halted in mode 3
		wr(OFS_CTRL, 8'h00);
		wr(OFS_MODE, 8'h30);
		wr(OFS_LO1, 8'h40);
		wr(OFS_CTRL, 8'h40);
		repeat (60) @(posedge clock);
		rdchk(OFS_LO1, 8'h40);
		chk({31'h0, timer1_irq}, 32'h00000000);
		close_out();
	end
endmodule
`default_nettype wire
